// File: sar_link_pkg.sv
// Shared constants and types for the converter control link
package sar_link_pkg;
    localparam int RES_BITS = 12;
    localparam int CODE_STEPS = 4096;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 300;
    localparam int ACQ_TIME_NS = 40;
    localparam int LIGHT_WAKE_NS = 300;
    localparam int DEEP_EXT_WAKE_US = 80;
    localparam int DEEP_INT_WAKE_MS = 500;
    // Longest times round down, least times round up
    localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LIGHT_WAKE_CYCLES = (LIGHT_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEEP_EXT_WAKE_CYCLES = (DEEP_EXT_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint DEEP_INT_WAKE_CYCLES_L = (64'(DEEP_INT_WAKE_MS) * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEEP_INT_WAKE_CYCLES = int'(DEEP_INT_WAKE_CYCLES_L);
    localparam int CNT_W = 25;
    localparam logic [RES_BITS-1:0] RESULT_RESET = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
    typedef enum logic [1:0] {
        DEV_TRACK = 2'b00,
        DEV_CONVERT = 2'b01
    } dev_state_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_WAKE = 2'b01,
        HOST_PULSE = 2'b10,
        HOST_BUSY = 2'b11
    } host_state_t;
endpackage : sar_link_pkg

// File: sar_link_if.sv
// Control pins between the host sequencer and the converter
`timescale 1ns/1ps
interface sar_link_if;
    logic convert_start_n;
    logic light_sleep_pin;
    logic deep_sleep_pin;
    logic reset_n;
    modport host (output convert_start_n, output light_sleep_pin, output deep_sleep_pin, output reset_n);
    modport device (input convert_start_n, input light_sleep_pin, input deep_sleep_pin, input reset_n);
endinterface : sar_link_if

// File: sar_conv_device.sv
// Converter end: conversion start, timing, sampler state and result
`timescale 1ns/1ps
// Overview of operation
// - Start-edge falling: hold sample, begin conversion
// - Conversion ends after 300 ns, result stored
// - End of conversion returns sampler to tracking
// - Result straight binary, twelve bits, Vref/4096
// - Host drives sleep pins high to sleep
// - Host waits 300 ns after light sleep
// - Light sleep only with external reference
// - Internal reference: deep-sleep release 500 ms ahead
// - External reference: wait 80 us after deep
// - Early conversions give invalid unflagged results
// - Reset falling edge restarts and aborts
// - Host never reads data during conversion
module sar_conv_device
    import sar_link_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    sar_link_if.device link,
    input wire logic [RES_BITS-1:0] sample_code_i,
    output logic holding_o,
    output logic busy_o,
    output logic done_o,
    output logic [RES_BITS-1:0] result_o,
    output logic asleep_o
);
    typedef struct packed {
        dev_state_t state;
        logic cs_prev;
        logic [CNT_W-1:0] cnt;
        logic [RES_BITS-1:0] held;
        logic [RES_BITS-1:0] approx;
        logic hold;
        logic busy;
        logic done;
        logic asleep;
    } dev_reg_t;
    dev_reg_t r_q;
    dev_reg_t r_d;
    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.cs_prev = link.convert_start_n;
        r_d.done = 1'b0;
        r_d.asleep = link.light_sleep_pin | link.deep_sleep_pin;
        case (r_q.state)
            DEV_TRACK: begin
                if (r_q.cs_prev && !link.convert_start_n && !r_d.asleep) begin
                    r_d.state = DEV_CONVERT;
                    r_d.hold = 1'b1;
                    r_d.busy = 1'b1;
                    r_d.held = sample_code_i;
                    r_d.cnt = CNT_ZERO;
                end
            end
            DEV_CONVERT: begin
                r_d.cnt = r_q.cnt + 25'h0000001;
                if (r_q.cnt == CNT_W'(CONV_CYCLES - 1)) begin
                    r_d.state = DEV_TRACK;
                    r_d.approx = r_q.held;
                    r_d.hold = 1'b0;
                    r_d.busy = 1'b0;
                    r_d.done = 1'b1;
                end
            end
            default: begin
                r_d.state = DEV_TRACK;
            end
        endcase
        if (!link.reset_n) begin
            r_d.state = DEV_TRACK;
            r_d.hold = 1'b0;
            r_d.busy = 1'b0;
            r_d.done = 1'b0;
            r_d.cnt = CNT_ZERO;
        end
    end
    // State register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '{state: DEV_TRACK, cs_prev: 1'b1, cnt: CNT_ZERO, held: RESULT_RESET,
                     approx: RESULT_RESET, hold: 1'b0, busy: 1'b0, done: 1'b0, asleep: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end
    // Outputs straight from flops
    assign holding_o = r_q.hold;
    assign busy_o = r_q.busy;
    assign done_o = r_q.done;
    assign result_o = r_q.approx;
    assign asleep_o = r_q.asleep;
endmodule : sar_conv_device

// File: sar_conv_host.sv
// Host end: sleep control, wake-up timing and convert-start pulses
`timescale 1ns/1ps
module sar_conv_host
    import sar_link_pkg::*;
#(
    parameter int DEEP_INT_WAKE = DEEP_INT_WAKE_CYCLES,
    parameter int DEEP_EXT_WAKE = DEEP_EXT_WAKE_CYCLES
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    sar_link_if.host link,
    input wire logic start_i,
    input wire logic light_sleep_i,
    input wire logic deep_sleep_i,
    input wire logic ext_ref_i,
    input wire logic dev_reset_i,
    output logic ready_o,
    output logic conv_busy_o,
    output logic read_ok_o
);
    typedef struct packed {
        host_state_t state;
        logic [CNT_W-1:0] cnt;
        logic cs_n;
        logic light;
        logic deep;
        logic rst_n;
        logic ready;
        logic busy;
        logic read_ok;
    } host_reg_t;
    host_reg_t r_q;
    host_reg_t r_d;
    // Wake time for the mode being left
    function automatic logic [CNT_W-1:0] wake_cycles(input logic was_deep, input logic ext);
        if (!was_deep)
            return CNT_W'(LIGHT_WAKE_CYCLES);
        else if (ext)
            return CNT_W'(DEEP_EXT_WAKE);
        else
            return CNT_W'(DEEP_INT_WAKE);
    endfunction : wake_cycles
    always_comb begin
        r_d = r_q;
        r_d.rst_n = !dev_reset_i;
        if (r_q.cnt != CNT_ZERO)
            r_d.cnt = r_q.cnt - 25'h0000001;
        case (r_q.state)
            HOST_IDLE: begin
                if (deep_sleep_i) begin
                    r_d.deep = 1'b1;
                    r_d.state = HOST_WAKE;
                end else if (light_sleep_i && ext_ref_i) begin
                    r_d.light = 1'b1;
                    r_d.state = HOST_WAKE;
                end else if (start_i && r_q.cnt == CNT_ZERO) begin
                    r_d.cs_n = 1'b0;
                    r_d.busy = 1'b1;
                    r_d.state = HOST_PULSE;
                end
            end
            HOST_WAKE: begin
                if (r_q.deep && !deep_sleep_i) begin
                    r_d.deep = 1'b0;
                    r_d.cnt = wake_cycles(1'b1, ext_ref_i);
                    r_d.state = HOST_IDLE;
                end else if (r_q.light && !light_sleep_i) begin
                    r_d.light = 1'b0;
                    r_d.cnt = wake_cycles(1'b0, ext_ref_i);
                    r_d.state = HOST_IDLE;
                end
            end
            HOST_PULSE: begin
                r_d.cs_n = 1'b1;
                r_d.cnt = CNT_W'(CONV_CYCLES + ACQ_CYCLES - 1);
                r_d.state = HOST_BUSY;
            end
            HOST_BUSY: begin
                if (r_q.cnt == CNT_W'(ACQ_CYCLES))
                    r_d.busy = 1'b0;
                if (r_q.cnt == CNT_ZERO)
                    r_d.state = HOST_IDLE;
            end
            default: begin
                r_d.state = HOST_IDLE;
            end
        endcase
        r_d.ready = (r_d.state == HOST_IDLE) && (r_d.cnt == CNT_ZERO) && !r_d.light && !r_d.deep;
        // Read permission kept in its own flop so the output has no gate behind it
        r_d.read_ok = !r_d.busy;
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '{state: HOST_IDLE, cnt: CNT_ZERO, cs_n: 1'b1, light: 1'b0, deep: 1'b0,
                     rst_n: 1'b0, ready: 1'b0, busy: 1'b0, read_ok: 1'b1};
        end else begin
            r_q <= r_d;
        end
    end
    assign link.convert_start_n = r_q.cs_n;
    assign link.light_sleep_pin = r_q.light;
    assign link.deep_sleep_pin = r_q.deep;
    assign link.reset_n = r_q.rst_n;
    assign ready_o = r_q.ready;
    assign conv_busy_o = r_q.busy;
    assign read_ok_o = r_q.read_ok;
endmodule : sar_conv_host

// File: sar_link_sva.sv
// Link checker: start spacing, pulse width and wake-up intervals
`timescale 1ns/1ps
module sar_link_sva
    import sar_link_pkg::*;
#(
    parameter int DEEP_EXT_WAKE = DEEP_EXT_WAKE_CYCLES
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic convert_start_n,
    input wire logic light_sleep_pin,
    input wire logic deep_sleep_pin,
    input wire logic reset_n
);
    localparam int SPACE = CONV_CYCLES + ACQ_CYCLES;
    logic [7:0] gap_q;
    logic [15:0] wake_q;
    logic [15:0] deep_q;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Saturating cycle counts since the last start and each sleep release
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= 8'hFF;
            wake_q <= 16'hFFFF;
            deep_q <= 16'hFFFF;
        end else begin
            gap_q <= $fell(convert_start_n) ? 8'h01 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
            wake_q <= light_sleep_pin ? 16'h0000 : (wake_q == 16'hFFFF ? wake_q : wake_q + 16'h0001);
            deep_q <= deep_sleep_pin ? 16'h0000 : (deep_q == 16'hFFFF ? deep_q : deep_q + 16'h0001);
        end
    end
    start_spacing_a: assert property ($fell(convert_start_n) |-> gap_q >= SPACE)
        else $error("starts closer than conversion plus acquisition");
    pulse_width_a: assert property ($fell(convert_start_n) |=> convert_start_n)
        else $error("start pulse longer than one cycle");
    acq_quiet_a: assert property ($fell(convert_start_n) |=> convert_start_n [*8])
        else $error("start during conversion");
    sleep_quiet_a: assert property ((light_sleep_pin || deep_sleep_pin) |-> convert_start_n)
        else $error("start issued while asleep");
    light_wake_a: assert property ($fell(convert_start_n) |-> wake_q >= LIGHT_WAKE_CYCLES)
        else $error("start too soon after light sleep");
    deep_wake_a: assert property ($fell(convert_start_n) |-> deep_q >= DEEP_EXT_WAKE)
        else $error("start too soon after deep sleep");
    sleep_hold_a: assert property ($rose(light_sleep_pin) |-> !deep_sleep_pin || $past(deep_sleep_pin))
        else $error("sleep pins raised together");
    cover property ($fell(convert_start_n) && wake_q < 16'h0100);
    cover property ($fell(convert_start_n) && deep_q < 16'h0100);
    cover property ($fell(reset_n));
endmodule : sar_link_sva

// File: sar_adc_convert_power_sequencing_bench.sv
// Bench joining host and converter ends over the control link
`timescale 1ns/1ps
module sar_adc_convert_power_sequencing_bench;
    import sar_link_pkg::*;
    localparam int INT_W = 50;
    localparam int EXT_W = 20;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic light_i = 1'b0;
    logic deep_i = 1'b0;
    logic ext_ref = 1'b1;
    logic dev_rst = 1'b0;
    logic [11:0] code = 12'h000;
    logic [11:0] last;
    logic ready_o, conv_busy, read_ok, holding, busy, done, asleep;
    logic [11:0] result;
    logic [11:0] q[$];
    int failures = 0;
    int cmp_count = 0;
    int bcnt = 0;
    int n;
    sar_link_if link();
    sar_conv_host #(.DEEP_INT_WAKE(INT_W), .DEEP_EXT_WAKE(EXT_W)) i_sar_conv_host (.mclk_i(mclk_i), .rst_i(rst_i),
        .link(link), .start_i(start_i), .light_sleep_i(light_i), .deep_sleep_i(deep_i), .ext_ref_i(ext_ref),
        .dev_reset_i(dev_rst), .ready_o(ready_o), .conv_busy_o(conv_busy), .read_ok_o(read_ok));
    sar_conv_device i_sar_conv_device (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .sample_code_i(code),
        .holding_o(holding), .busy_o(busy), .done_o(done), .result_o(result), .asleep_o(asleep));
    sar_link_sva #(.DEEP_EXT_WAKE(EXT_W)) i_sar_link_sva (.mclk_i(mclk_i), .rst_i(rst_i),
        .convert_start_n(link.convert_start_n), .light_sleep_pin(link.light_sleep_pin),
        .deep_sleep_pin(link.deep_sleep_pin), .reset_n(link.reset_n));
    // Clock generation
    initial forever #10 mclk_i = ~mclk_i;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // Bounded wait for the host to allow a start, counting edges
    task wait_ready(output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk_i);
            cnt++;
            if (cnt > 2000) begin
                failures++;
                give_verdict();
            end
        end while (ready_o !== 1'b1);
    endtask : wait_ready
    task convert(input logic [11:0] c);
        int w;
        wait_ready(w);
        code <= c;
        start_i <= 1'b1;
        q.push_back(c);
        last = c;
        @(posedge mclk_i);
        start_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk(holding, 1);
        chk(read_ok, 0);
        chk(conv_busy, 1);
    endtask : convert
    // Result monitor: oldest note against each finished conversion
    always @(posedge mclk_i) begin
        if (done === 1'b1) begin
            chk(q.size() > 0, 1);
            if (q.size() > 0) chk(result, q.pop_front());
            chk(bcnt, CONV_CYCLES);
        end
        bcnt <= (busy === 1'b1) ? bcnt + 1 : 0;
    end
    initial begin
        void'($urandom(32'hDF5A));
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        convert(12'h000);
        convert(12'hFFF);
        for (int i = 0; i < 6; i++) convert(12'($urandom));
        // Light sleep with external reference; starts while asleep are dropped
        wait_ready(n);
        light_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(link.light_sleep_pin, 1);
        chk(asleep, 1);
        start_i <= 1'b1;
        repeat (30) @(posedge mclk_i);
        start_i <= 1'b0;
        light_i <= 1'b0;
        wait_ready(n);
        chk(n >= LIGHT_WAKE_CYCLES, 1);
        convert(12'($urandom));
        // Light sleep refused on the internal reference
        wait_ready(n);
        ext_ref <= 1'b0;
        light_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(link.light_sleep_pin, 0);
        light_i <= 1'b0;
        // Deep sleep on both references
        for (int i = 0; i < 2; i++) begin
            wait_ready(n);
            ext_ref <= i[0];
            deep_i <= 1'b1;
            repeat (3) @(posedge mclk_i);
            chk(link.deep_sleep_pin, 1);
            deep_i <= 1'b0;
            wait_ready(n);
            chk(n >= (i == 1 ? EXT_W : INT_W), 1);
            convert(12'($urandom));
        end
        // Device reset in mid-conversion aborts and keeps the old result
        wait_ready(n);
        code <= 12'h5A5;
        start_i <= 1'b1;
        @(posedge mclk_i);
        start_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        dev_rst <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(link.reset_n, 0);
        chk(busy, 0);
        dev_rst <= 1'b0;
        repeat (20) @(posedge mclk_i);
        chk(result, last);
        convert(12'hABC);
        wait_ready(n);
        chk(q.size(), 0);
        give_verdict();
    end
endmodule : sar_adc_convert_power_sequencing_bench
